/* File: rtl/clk_phase_gen.sv */
// Divide-by-two state clock and machine cycle phase strobes
`timescale 1ns/1ns
module clk_phase_gen import wdt_pwr_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic run,
	output phase_t phase
);

	logic half_q;
	state_t st_q;
	state_t st_d;

	always_comb begin
		case (st_q)
			ST_S1: st_d = ST_S2;
			ST_S2: st_d = ST_S3;
			ST_S3: st_d = ST_S4;
			ST_S4: st_d = ST_S5;
			ST_S5: st_d = ST_S6;
			ST_S6: st_d = ST_S1;
			default: st_d = ST_S1;
		endcase
	end

	// Halving first makes state timing immune to input duty cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			half_q <= 1'b0;
			st_q <= ST_S1;
		end else if (run) begin
			half_q <= ~half_q;
			if (half_q) begin
				st_q <= st_d;
			end
		end
	end

	assign phase.state_en = run & half_q;
	assign phase.state5_phase2 = run & half_q & (st_q == ST_S5);
	assign phase.mcycle = run & half_q & (st_q == ST_S6);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn || !run);

	a_mcycle_period: assert property (phase.mcycle |-> ##12 phase.mcycle) else $error("machine cycle is not twelve clocks");
	a_state_half: assert property (phase.state_en |=> !phase.state_en ##1 phase.state_en) else $error("state enable not at half rate");

endmodule

/* File: rtl/rst_deglitch.sv */
// Reset pin sampler that needs consecutive high samples
`timescale 1ns/1ns
module rst_deglitch import wdt_pwr_pkg::*; #(
	parameter int SAMPLES = RST_HOLD_MCYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sample,
	input wire logic pin,
	output logic active_q
);

	logic [SAMPLES-1:0] hist_q;
	logic [SAMPLES-1:0] hist_d;

	if (SAMPLES < 2) begin : g_chk
		$error("rst_deglitch needs at least two samples");
	end

	assign hist_d = {hist_q[SAMPLES-2:0], pin};

	// Sampled only at the strobe; a pulse shorter than the span is ignored
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hist_q <= '0;
			active_q <= 1'b0;
		end else if (sample) begin
			hist_q <= hist_d;
			active_q <= &hist_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_sample_only: assert property (!sample |=> $stable(active_q)) else $error("reset changed off the sample strobe");
	a_needs_run: assert property ($rose(active_q) |-> $past(sample && pin && hist_q[0])) else $error("reset taken on a single sample");

endmodule

/* File: rtl/watchdog_power_reset_ctrl.sv */
// Watchdog, idle and power-down control, power-off flag and reset
`timescale 1ns/1ns
//
// Contract
// - Every reset disables the watchdog and clears its counter.
// - Watchdog counts only while its enable bit 7 is set.
// - Clear bit resets counter, prescaler and itself next instruction cycle.
// - In idle, watchdog runs only if idle-run bit 5 set; resets to zero.
// - Three-bit select picks prescale ratio 2 to 256 in powers of two.
// - Timeout equals 2^14 times ratio times twelve oscillator periods.
// - An enabled watchdog timeout causes a system reset.
// - Oscillator is divided by two internally before use.
// - Idle bit stops processor clock; peripherals keep running.
// - Interrupt or reset ends idle mode.
// - Power-down stops all clocks and oscillator; only reset exits.
// - Power-off flag bit 4 set at power-on, software clears, kept otherwise.
// - Two general-purpose flags are freely read and written.
// - Reset pin sampled at state 5 phase 2; held two machine cycles.
// - Reset input is deglitched so short pulses do nothing.
// - Reset clears registers to 00H; ports FFH, stack pointer 07H (no ports or stack pointer here; PORT_RESET_VAL and SP_RESET_VAL go unused).
module watchdog_power_reset_ctrl import wdt_pwr_pkg::*; #(
	parameter int CNT_W = WD_COUNT_W,
	parameter int PRE_W = PRESC_W
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic rst_pin,
	input wire logic irq_req,
	input wire sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	output logic sys_reset,
	output logic osc_run,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic wd_timeout
);

	if (CNT_W < 2 || PRE_W < PS_W + 1 || PRE_W > 31) begin : g_chk
		$error("watchdog widths out of range");
	end

	// Mask of prescaler bits that must all be one for a tick
	function automatic logic [PRE_W-1:0] prescale_mask(
		input logic [PS_W-1:0] sel
	);
		logic [PRE_W:0] one_hot;
		one_hot = '0;
		one_hot[sel + 1] = 1'b1;
		return PRE_W'(one_hot - 1'b1);
	endfunction

	phase_t ph;
	logic pin_rst;
	logic sys_rst;

	logic enw_q;
	logic clr_q;
	logic clr_d;
	logic wd_idle_run_bit_q;
	logic [PS_W-1:0] ps_q;
	logic pof_q;
	logic gf1_q;
	logic gf0_q;
	logic pd_q;
	logic idl_q;
	logic [PRE_W-1:0] presc_q;
	logic [CNT_W-1:0] cnt_q;
	logic [1:0] hold_q;
	logic [7:0] rdata_q;

	wire wr_power_control = sfr_req.wr && (sfr_req.addr == POWER_CONTROL_ADDR);
	wire wr_watchdog_control = sfr_req.wr && (sfr_req.addr == WATCHDOG_CONTROL_ADDR);
	wire rd_power_control = sfr_req.addr == POWER_CONTROL_ADDR;
	wire rd_watchdog_control = sfr_req.addr == WATCHDOG_CONTROL_ADDR;
	wire [PRE_W-1:0] mask = prescale_mask(ps_q);

	wire [7:0] power_control_view = {3'h0, pof_q, gf1_q, gf0_q, pd_q, idl_q};
	wire [7:0] watchdog_control_view = {enw_q, clr_q, wd_idle_run_bit_q, 2'h0, ps_q};
	wire [7:0] rd_mux = rd_power_control ? power_control_view :
		rd_watchdog_control ? watchdog_control_view : SFR_RESET_VAL;

	// Counting gated by enable and by idle policy
	wire run_ok = ph.mcycle && enw_q && (!idl_q || wd_idle_run_bit_q);
	wire clr_now = clr_q && ph.mcycle;
	wire presc_tick = run_ok && ((presc_q & mask) == mask);
	wire overflow = presc_tick && (&cnt_q);

	// Oscillator restarts only while the pin is pulled high
	assign osc_run = !pd_q || rst_pin;

	clk_phase_gen u_phase (
		.clk(clk),
		.resetn(resetn),
		.run(osc_run),
		.phase(ph)
	);

	rst_deglitch #(
		.SAMPLES(RST_HOLD_MCYCLES)
	) u_rst (
		.clk(clk),
		.resetn(resetn),
		.sample(ph.state5_phase2),
		.pin(rst_pin),
		.active_q(pin_rst)
	);

	assign sys_rst = pin_rst || (hold_q != 2'h0);
	assign sys_reset = sys_rst;
	assign wd_timeout = overflow;
	assign sfr_rdata = rdata_q;
	assign cpu_clk_en = ph.state_en && !idl_q && !pd_q;
	assign periph_clk_en = ph.state_en;

	// A fresh write of one beats the self-clear in the same cycle
	assign clr_d = (wr_watchdog_control && sfr_req.wdata[WATCHDOG_CONTROL_CLR_BIT]) ||
		(clr_q && !ph.mcycle);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			enw_q <= WATCHDOG_CONTROL_RESET[WATCHDOG_CONTROL_ENW_BIT];
			clr_q <= WATCHDOG_CONTROL_RESET[WATCHDOG_CONTROL_CLR_BIT];
			wd_idle_run_bit_q <= WATCHDOG_CONTROL_RESET[WATCHDOG_CONTROL_WD_IDLE_RUN_BIT_BIT];
			ps_q <= PS_RESET;
		end else if (sys_rst) begin
			enw_q <= WATCHDOG_CONTROL_RESET[WATCHDOG_CONTROL_ENW_BIT];
			clr_q <= WATCHDOG_CONTROL_RESET[WATCHDOG_CONTROL_CLR_BIT];
			wd_idle_run_bit_q <= WATCHDOG_CONTROL_RESET[WATCHDOG_CONTROL_WD_IDLE_RUN_BIT_BIT];
			ps_q <= PS_RESET;
		end else begin
			clr_q <= clr_d;
			if (wr_watchdog_control) begin
				enw_q <= sfr_req.wdata[WATCHDOG_CONTROL_ENW_BIT];
				wd_idle_run_bit_q <= sfr_req.wdata[WATCHDOG_CONTROL_WD_IDLE_RUN_BIT_BIT];
				ps_q <= sfr_req.wdata[WATCHDOG_CONTROL_PS_LSB +: PS_W];
			end
		end
	end

	// Prescaler and counter share the clear and the reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			presc_q <= '0;
			cnt_q <= '0;
		end else if (sys_rst || clr_now) begin
			presc_q <= '0;
			cnt_q <= '0;
		end else if (run_ok) begin
			presc_q <= presc_q + 1'b1;
			if (presc_tick) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// Timeout reset is stretched so the whole chip sees it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hold_q <= 2'h0;
		end else if (overflow) begin
			hold_q <= 2'(RST_HOLD_MCYCLES);
		end else if (ph.mcycle && hold_q != 2'h0) begin
			hold_q <= hold_q - 2'h1;
		end
	end

	// Power-off flag sees only power-on reset, never pin or watchdog
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pof_q <= POF_POR_VAL;
		end else if (wr_power_control) begin
			pof_q <= sfr_req.wdata[POWER_CONTROL_POF_BIT];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gf1_q <= SFR_RESET_VAL[POWER_CONTROL_GF1_BIT];
			gf0_q <= SFR_RESET_VAL[POWER_CONTROL_GF0_BIT];
			pd_q <= SFR_RESET_VAL[POWER_CONTROL_PD_BIT];
			idl_q <= SFR_RESET_VAL[POWER_CONTROL_IDL_BIT];
		end else if (sys_rst) begin
			gf1_q <= SFR_RESET_VAL[POWER_CONTROL_GF1_BIT];
			gf0_q <= SFR_RESET_VAL[POWER_CONTROL_GF0_BIT];
			pd_q <= SFR_RESET_VAL[POWER_CONTROL_PD_BIT];
			idl_q <= SFR_RESET_VAL[POWER_CONTROL_IDL_BIT];
		end else if (wr_power_control) begin
			gf1_q <= sfr_req.wdata[POWER_CONTROL_GF1_BIT];
			gf0_q <= sfr_req.wdata[POWER_CONTROL_GF0_BIT];
			pd_q <= sfr_req.wdata[POWER_CONTROL_PD_BIT];
			idl_q <= sfr_req.wdata[POWER_CONTROL_IDL_BIT];
		end else if (irq_req) begin
			idl_q <= 1'b0;
		end
	end

	// Unmapped addresses read as zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= SFR_RESET_VAL;
		end else if (sfr_req.rd) begin
			rdata_q <= rd_mux;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_reset_disables: assert property (sys_rst |=> !enw_q && cnt_q == '0 && presc_q == '0) else $error("reset left watchdog running");
	a_count_gated: assert property ((!enw_q && !sys_rst && !clr_now) |=> cnt_q == $past(cnt_q) && presc_q == $past(presc_q)) else $error("disabled watchdog counted");
	a_clear_self: assert property ((clr_now && !wr_watchdog_control) |=> !clr_q && cnt_q == '0 && presc_q == '0) else $error("clear bit did not clear");
	a_clear_waits: assert property ((wr_watchdog_control && sfr_req.wdata[WATCHDOG_CONTROL_CLR_BIT] && !sys_rst) |=> clr_q ##[1:12] !clr_q) else $error("clear bit held past a machine cycle");
	a_idle_halt: assert property ((idl_q && !wd_idle_run_bit_q && !sys_rst && !clr_now) |=> $stable(cnt_q) && $stable(presc_q)) else $error("watchdog ran in idle");
	a_tick_ratio: assert property ((presc_tick && !sys_rst && !clr_now && !wr_watchdog_control) |=> (presc_q & mask) == '0) else $error("prescaler tick off ratio");
	a_timeout_rst: assert property (overflow |=> sys_rst [*8]) else $error("timeout gave no reset");
	a_idle_clk: assert property ((idl_q || pd_q) |-> !cpu_clk_en) else $error("cpu clocked in idle");
	a_idle_exit: assert property ((idl_q && irq_req && !wr_power_control && !sys_rst) |=> !idl_q && periph_clk_en == ph.state_en) else $error("interrupt did not end idle");
	a_pd_stops: assert property ((pd_q && !rst_pin) |-> !osc_run && !periph_clk_en) else $error("clock ran in power down");
	a_pd_exit: assert property ((pd_q && !pin_rst && !sys_rst && !wr_power_control) |=> pd_q) else $error("power down left without reset");
	a_pof_kept: assert property ((sys_rst && !wr_power_control) |=> $stable(pof_q)) else $error("power-off flag hit by reset");
	a_power_control_reset: assert property (sys_rst |=> {gf1_q, gf0_q, pd_q, idl_q} == 4'h0) else $error("power control not cleared");

	c_timeout: cover property (overflow ##1 sys_rst);
	c_clear: cover property (clr_now ##1 !clr_q);
	c_idle_exit: cover property (idl_q && irq_req ##1 !idl_q);
	c_pd_wake: cover property (pd_q ##[1:100] !pd_q);

endmodule

/* File: rtl/wdt_pwr_pkg.sv */
// Shared constants, types and register layout for supervision logic
package wdt_pwr_pkg;

	// Register addresses on the special function register port
	localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
	localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'h8F;

	// Watchdog control fields
	localparam int WATCHDOG_CONTROL_ENW_BIT = 7;
	localparam int WATCHDOG_CONTROL_CLR_BIT = 6;
	localparam int WATCHDOG_CONTROL_WD_IDLE_RUN_BIT_BIT = 5;
	localparam int WATCHDOG_CONTROL_PS_LSB = 0;
	localparam int PS_W = 3;

	// Power control fields
	localparam int POWER_CONTROL_POF_BIT = 4;
	localparam int POWER_CONTROL_GF1_BIT = 3;
	localparam int POWER_CONTROL_GF0_BIT = 2;
	localparam int POWER_CONTROL_PD_BIT = 1;
	localparam int POWER_CONTROL_IDL_BIT = 0;

	// Reset values
	localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h00;
	localparam logic [7:0] SFR_RESET_VAL = 8'h00;
	localparam logic [7:0] PORT_RESET_VAL = 8'hFF;
	localparam logic [7:0] SP_RESET_VAL = 8'h07;
	localparam logic POF_POR_VAL = 1'b1;
	localparam logic [PS_W-1:0] PS_RESET = 3'h0;

	// Timing: oscillator periods per state, states per machine cycle
	localparam int OSC_PER_STATE = 2;
	localparam int STATES_PER_MCYCLE = 6;
	localparam int OSC_PER_MCYCLE = OSC_PER_STATE * STATES_PER_MCYCLE;
	localparam int RST_HOLD_MCYCLES = 2;
	localparam int WD_COUNT_W = 14;
	localparam int PRESC_W = 8;

	typedef enum logic [2:0] {ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_S6} state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic state_en;
		logic state5_phase2;
		logic mcycle;
	} phase_t;

endpackage

/* File: tb/cpu_model.sv */
// Processor core model issuing register reads and writes
`timescale 1ns/1ns
module cpu_model import wdt_pwr_pkg::*; (
	input wire logic clk,
	input wire logic [7:0] sfr_rdata,
	output sfr_req_t sfr_req
);
	initial sfr_req = '0;

	// Strobe lasts one cycle; the caller never re-enters in the same step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		sfr_req <= '0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfr_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		sfr_req <= '0;
		@(posedge clk);
		#1 d = sfr_rdata;
	endtask

	// Service write that keeps a healthy program from being reset
	task automatic kick(input logic [7:0] cfg);
		wr(WATCHDOG_CONTROL_ADDR, cfg | 8'h40);
	endtask
endmodule

/* File: tb/watchdog_power_reset_ctrl_test.sv */
// Self-checking bench for watchdog, power modes and reset pin
`timescale 1ns/1ns
module watchdog_power_reset_ctrl_test import wdt_pwr_pkg::*; ;
	// Short counter keeps each timeout between 384 and 3072 cycles
	localparam int CW = 4;
	logic clk = 1'b0, resetn = 1'b0, rst_pin = 1'b0, irq_req = 1'b0;
	sfr_req_t sfr_req;
	logic [7:0] sfr_rdata, d;
	logic sys_reset, osc_run, cpu_clk_en, periph_clk_en, wd_timeout;
	int num_errors = 0, compares = 0, n, c, p;

	initial forever #25 clk = ~clk;

	watchdog_power_reset_ctrl #(.CNT_W(CW), .PRE_W(PRESC_W)) DUT (
		.clk(clk), .resetn(resetn), .rst_pin(rst_pin),
		.irq_req(irq_req), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
		.sys_reset(sys_reset), .osc_run(osc_run), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .wd_timeout(wd_timeout)
	);
	cpu_model cpu(.clk(clk), .sfr_rdata(sfr_rdata), .sfr_req(sfr_req));

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chkr(input int g, input int lo, input int hi);
		compares++;
		if (g < lo || g > hi) begin
			num_errors++;
			$display("[FAIL] %0t count %0d not in %0d..%0d", $time, g, lo, hi);
		end
	endtask

	task automatic clks(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic wait_to(input int lim, output int k);
		k = 0;
		while (wd_timeout !== 1'b1 && k < lim) begin
			@(posedge clk);
			#1 k++;
		end
	endtask

	task automatic en_cnt(input int k, output int cc, output int pc);
		cc = 0;
		pc = 0;
		repeat (k) begin
			@(posedge clk);
			#1 cc += (cpu_clk_en === 1'b1);
			pc += (periph_clk_en === 1'b1);
		end
	endtask

	// Strobe phase is unknown at the start, hence the slack of 14 cycles early and 12 late
	task automatic expect_to(input int e);
		wait_to(e + 2000, n);
		chkr(n, e - 14, e + 12);
		@(posedge clk);
		#1 chk8({7'h00, sys_reset}, 8'h01);
		clks(30);
		cpu.rd(WATCHDOG_CONTROL_ADDR, d);
		chk8(d, 8'h00);
	endtask

	task automatic conclude;
		if (num_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#2_000_000;
		num_errors++;
		$display("[FAIL] %0t run did not finish", $time);
		conclude;
	end

	initial begin
		clks(16);
		resetn <= 1'b1;
		cpu.rd(POWER_CONTROL_ADDR, d);
		chk8(d, 8'h10);
		cpu.rd(WATCHDOG_CONTROL_ADDR, d);
		chk8(d, 8'h00);
		cpu.rd(8'h20, d);
		chk8(d, 8'h00);
		cpu.wr(POWER_CONTROL_ADDR, 8'h0C);
		cpu.rd(POWER_CONTROL_ADDR, d);
		chk8(d, 8'h0C);
		cpu.wr(POWER_CONTROL_ADDR, 8'h00);
		en_cnt(20, c, p);
		chkr(c + p, 20, 20);
		for (int s = 0; s < 4; s++) begin
			cpu.wr(WATCHDOG_CONTROL_ADDR, 8'h80 | 8'(s));
			expect_to(12 << (CW + s + 1));
		end
		cpu.wr(WATCHDOG_CONTROL_ADDR, 8'h80);
		repeat (3) begin
			clks(250);
			cpu.kick(8'h80);
		end
		clks(14);
		cpu.rd(WATCHDOG_CONTROL_ADDR, d);
		chk8(d, 8'h80);
		expect_to((12 << (CW + 1)) - 17);
		cpu.wr(WATCHDOG_CONTROL_ADDR, 8'h00);
		wait_to(600, n);
		chkr(n, 600, 600);
		cpu.wr(WATCHDOG_CONTROL_ADDR, 8'h80);
		cpu.wr(POWER_CONTROL_ADDR, 8'h01);
		en_cnt(24, c, p);
		chkr(c, 0, 0);
		chkr(p, 12, 12);
		wait_to(600, n);
		chkr(n, 600, 600);
		@(posedge clk) irq_req <= 1'b1;
		clks(2);
		irq_req <= 1'b0;
		en_cnt(20, c, p);
		chkr(c, 10, 10);
		cpu.wr(WATCHDOG_CONTROL_ADDR, 8'h00);
		cpu.wr(WATCHDOG_CONTROL_ADDR, 8'hE0);
		cpu.wr(POWER_CONTROL_ADDR, 8'h01);
		expect_to((12 << (CW + 1)) - 2);
		cpu.rd(POWER_CONTROL_ADDR, d);
		chk8(d, 8'h00);
		cpu.wr(POWER_CONTROL_ADDR, 8'h02);
		#1 chk8({7'h00, osc_run}, 8'h00);
		en_cnt(24, c, p);
		chkr(c + p, 0, 0);
		@(posedge clk) rst_pin <= 1'b1;
		clks(30);
		#1 chk8({7'h00, sys_reset}, 8'h01);
		@(posedge clk) rst_pin <= 1'b0;
		clks(14);
		#1 chk8({6'h00, sys_reset, osc_run}, 8'h01);
		cpu.rd(POWER_CONTROL_ADDR, d);
		chk8(d, 8'h00);
		@(posedge clk) rst_pin <= 1'b1;
		clks(6);
		rst_pin <= 1'b0;
		n = 0;
		repeat (30) begin
			@(posedge clk);
			#1 n += (sys_reset === 1'b1);
		end
		chkr(n, 0, 0);
		conclude;
	end
endmodule
